// [rtl/bus_arb_pkg.sv]
package bus_arb_pkg;

  // ****************************************************************
  // clock family
  // ****************************************************************
  // master crystal divided by 8 gives the colour clock
  localparam int unsigned CRYSTAL_NTSC_HZ   = 28636360;
  localparam int unsigned CRYSTAL_PAL_HZ    = 28375160;
  localparam int unsigned COLOUR_CLOCK_HZ   = 3579545;
  localparam int unsigned CPU_DOUBLE_HZ     = 7159090;
  localparam int unsigned PHASE_QUAD_DEG    = 45;
  localparam int unsigned PHASE_DELAYED_DEG = 90;
  localparam int unsigned PHASE_STEP_DEG    = 45;
  localparam int unsigned PHASE_STEPS       = 360 / PHASE_STEP_DEG;
  localparam logic [2:0]  QUAD_LAG_STEPS    = 3'(PHASE_QUAD_DEG / PHASE_STEP_DEG);
  // 90 degrees of the doubled clock is 45 degrees of the colour clock
  localparam logic [2:0]  DELAY_LAG_STEPS   = 3'(PHASE_DELAYED_DEG / 2 / PHASE_STEP_DEG);
  // reset one count before a colour-clock rise, where every derived clock is low
  localparam logic [2:0]  PHASE_RESET       = 3'h7;
  // processor cycles must end in the colour-clock phase where it is high
  localparam logic        CYCLE_END_PHASE   = 1'h1;

  // ****************************************************************
  // buses
  // ****************************************************************
  localparam int unsigned CPU_ADDR_W  = 23;
  localparam int unsigned DRAM_ADDR_W = 9;
  localparam int unsigned REG_SEL_W   = 8;
  localparam int unsigned DMA_ADDR_W  = 18;
  localparam logic [7:0]  REG_SEL_IDLE    = 8'hff;
  localparam logic [7:0]  REG_SEL_REFRESH = 8'h3c;
  localparam logic [8:0]  REFRESH_ROWS    = 9'h1ff;

  typedef enum {ARB_CPU, ARB_DMA} arb_state_t;
  typedef enum {MEM_IDLE, MEM_ROW, MEM_COL, MEM_DONE} mem_state_t;

endpackage : bus_arb_pkg

// [rtl/clock_family_gen.sv]
`timescale 1ns/1ps
module clock_family_gen
  import bus_arb_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  output logic      colour_clock_primary_o,
  output logic      colour_clock_quadrature_o,
  output logic      cpu_clock_double_o,
  output logic      cpu_clock_delayed_o,
  output logic      colour_edge_o
);

  // ****************************************************************
  // phase counter
  // ****************************************************************
  // clk_sys stands in for the crystal; one count is 45 degrees of the colour clock
  typedef struct packed {
    logic [2:0] phase;
    logic       c1;
    logic       c3;
    logic       dbl;
    logic       dly;
  } gen_t;

  gen_t cur;
  gen_t next_cur;

  function automatic logic half_high(input logic [2:0] p);
    return p < 3'h4;
  endfunction : half_high

  always_comb begin
    next_cur       = cur;
    next_cur.phase = cur.phase + 3'h1;
    next_cur.c1    = half_high(next_cur.phase);
    next_cur.c3    = half_high(next_cur.phase - QUAD_LAG_STEPS);
    next_cur.dbl   = next_cur.c1 ^ next_cur.c3;
    next_cur.dly   = half_high(next_cur.phase - DELAY_LAG_STEPS)
                   ^ half_high(next_cur.phase - QUAD_LAG_STEPS - DELAY_LAG_STEPS);
    if (sys_rst_i) begin
      next_cur       = '0;
      next_cur.phase = PHASE_RESET;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    cur <= next_cur;
  end

  assign colour_clock_primary_o    = cur.c1;
  assign colour_clock_quadrature_o = cur.c3;
  assign cpu_clock_double_o        = cur.dbl;
  assign cpu_clock_delayed_o       = cur.dly;
  assign colour_edge_o             = (cur.phase == 3'h7);

endmodule : clock_family_gen

// [rtl/dram_addr_mux.sv]
`timescale 1ns/1ps
module dram_addr_mux
  import bus_arb_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   cpu_path_i,
  input  wire logic                   col_phase_i,
  input  wire logic [CPU_ADDR_W-1:0]  cpu_addr_i,
  input  wire logic [DMA_ADDR_W-1:0]  dma_addr_i,
  output logic      [DRAM_ADDR_W-1:0] dram_addr_o
);

  // ****************************************************************
  // row / column multiplexer
  // ****************************************************************
  typedef struct packed {
    logic [DRAM_ADDR_W-1:0] addr;
  } mux_t;

  mux_t cur;
  mux_t next_cur;
  logic [DMA_ADDR_W-1:0] src;

  always_comb begin
    src = cpu_path_i ? cpu_addr_i[DMA_ADDR_W-1:0] : dma_addr_i;
    next_cur = cur;
    next_cur.addr = col_phase_i ? src[DRAM_ADDR_W-1:0]
                                : src[DMA_ADDR_W-1:DRAM_ADDR_W];
    if (sys_rst_i) begin
      next_cur = '0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    cur <= next_cur;
  end

  assign dram_addr_o = cur.addr;

endmodule : dram_addr_mux

// [rtl/display_bus_arbiter_clock_sync.sv]
// What this block does
// - all clocks are divided down from the crystal, synchronous to colour clock
// - quadrature colour clock lags primary colour clock by 45 degrees
// - processor clock is primary XOR quadrature, twice colour frequency
// - delayed processor clock lags doubled clock by 90 degrees
// - display side runs on colour clock, processor on synchronous doubled clock
// - a display cycle started in the wrong colour phase gets its acknowledge delayed
// - acknowledge withheld while dma holds buses and processor asks for them
// - processor reaches display buses only once bus drivers are enabled
// - display buses isolate so dma and processor cycles run concurrently
// - dma side makes all dram timing and row/column multiplexing
// - processor display cycles pass processor address onto dram lines
// - dma cycles drive dram lines from the dma address input, refresh cycles from the row counter
// - each dma cycle puts a cycle code on the register-select bus
// - dma side refreshes the one-bit-wide dynamic display ram
// - acknowledge held off for display cycles until display buses are free
`timescale 1ns/1ps
module display_bus_arbiter_clock_sync
  import bus_arb_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   cpu_as_n_i,
  input  wire logic                   cpu_display_sel_i,
  input  wire logic [CPU_ADDR_W-1:0]  cpu_addr_i,
  input  wire logic                   custom_bus_claim_n_i,
  input  wire logic                   dma_start_i,
  input  wire logic [DMA_ADDR_W-1:0]  dma_addr_i,
  input  wire logic [REG_SEL_W-1:0]   dma_code_i,
  input  wire logic                   refresh_req_i,
  output logic                        colour_clock_primary_o,
  output logic                        colour_clock_quadrature_o,
  output logic                        cpu_clock_double_o,
  output logic                        cpu_clock_delayed_o,
  output logic                        cpu_dtack_n_o,
  output logic                        cpu_drivers_en_o,
  output logic                        dma_grant_o,
  output logic [DRAM_ADDR_W-1:0]      dram_addr_o,
  output logic                        dram_ras_n_o,
  output logic                        dram_cas_n_o,
  output logic [REG_SEL_W-1:0]        register_select_bus_o,
  output logic                        dma_done_o
);

  // ****************************************************************
  // clocks
  // ****************************************************************
  logic c1;
  logic colour_edge;

  clock_family_gen u_clk (
    .clk_sys_i                 (clk_sys_i),
    .sys_rst_i                 (sys_rst_i),
    .colour_clock_primary_o    (c1),
    .colour_clock_quadrature_o (colour_clock_quadrature_o),
    .cpu_clock_double_o        (cpu_clock_double_o),
    .cpu_clock_delayed_o       (cpu_clock_delayed_o),
    .colour_edge_o             (colour_edge)
  );
  assign colour_clock_primary_o = c1;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // pins come from the processor and dma pads, two flops before use
  typedef struct packed {
    logic [1:0] as_n;
    logic [1:0] sel;
    logic [1:0] claim_n;
  } sync_t;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    sync_t                  s;
    arb_state_t             arb;
    mem_state_t             mem;
    logic                   dtack_n;
    logic                   drv_en;
    logic                   cpu_mem;
    logic                   ras_n;
    logic                   cas_n;
    logic [REG_SEL_W-1:0]   rsel;
    logic [DRAM_ADDR_W-1:0] ref_row;
    logic                   refresh;
    logic                   done;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic as_act;
  logic sel;
  logic claim;
  logic buses_free;
  logic col_phase;
  logic [DMA_ADDR_W-1:0] dma_src;

  always_comb begin
    as_act     = ~cur.s.as_n[1];
    sel        = cur.s.sel[1];
    claim      = ~cur.s.claim_n[1];
    buses_free = (cur.arb == ARB_CPU) && !claim;
    next_cur   = cur;
    next_cur.done = 1'h0;

    next_cur.s.as_n    = {cur.s.as_n[0], cpu_as_n_i};
    next_cur.s.sel     = {cur.s.sel[0], cpu_display_sel_i};
    next_cur.s.claim_n = {cur.s.claim_n[0], custom_bus_claim_n_i};

    // arbitration: the claim takes the buses at once
    case (cur.arb)
      ARB_CPU: begin
        if (claim) begin
          next_cur.arb = ARB_DMA;
        end
      end
      ARB_DMA: begin
        // release only on a colour-clock boundary so dram phases stay aligned
        if (!claim && colour_edge) begin
          next_cur.arb = ARB_CPU;
        end
      end
      default: next_cur.arb = ARB_CPU;
    endcase

    // processor side: drivers and acknowledge
    if (!as_act) begin
      next_cur.dtack_n = 1'h1;
      next_cur.drv_en  = 1'h0;
      next_cur.cpu_mem = 1'h0;
    end else if (!sel) begin
      // off the display buses the processor runs concurrently with dma
      next_cur.dtack_n = 1'h0;
    end else if (buses_free) begin
      next_cur.drv_en  = 1'h1;
      next_cur.cpu_mem = 1'h1;
      // acknowledge only once the buses are ours and c1 is in the right phase
      if (cur.drv_en && c1 == CYCLE_END_PHASE && cur.mem == MEM_DONE) begin
        next_cur.dtack_n = 1'h0;
      end
    end else begin
      next_cur.dtack_n = 1'h1;
      next_cur.drv_en  = 1'h0;
    end

    // dram timing, at most one access per two colour clocks
    case (cur.mem)
      MEM_IDLE: begin
        next_cur.rsel = REG_SEL_IDLE;
        if (colour_edge) begin
          if (cur.arb == ARB_DMA && refresh_req_i) begin
            next_cur.refresh = 1'h1;
            next_cur.ras_n   = 1'h0;
            next_cur.rsel    = REG_SEL_REFRESH;
            next_cur.mem     = MEM_ROW;
          end else if (cur.arb == ARB_DMA && dma_start_i) begin
            next_cur.refresh = 1'h0;
            next_cur.ras_n   = 1'h0;
            next_cur.rsel    = dma_code_i;
            next_cur.mem     = MEM_ROW;
          end else if (cur.arb == ARB_CPU && cur.cpu_mem) begin
            next_cur.refresh = 1'h0;
            next_cur.ras_n   = 1'h0;
            next_cur.mem     = MEM_ROW;
          end
        end
      end
      MEM_ROW: begin
        // refresh is ras-only; one bit wide parts need no column strobe
        next_cur.cas_n = cur.refresh;
        next_cur.mem   = MEM_COL;
      end
      MEM_COL: begin
        if (colour_edge) begin
          next_cur.ras_n = 1'h1;
          next_cur.cas_n = 1'h1;
          next_cur.mem   = MEM_DONE;
          next_cur.done  = (cur.arb == ARB_DMA);
          if (cur.refresh) begin
            next_cur.ref_row = cur.ref_row + 9'h1;
          end
        end
      end
      MEM_DONE: begin
        next_cur.rsel = REG_SEL_IDLE;
        if (!as_act || cur.arb == ARB_DMA) begin
          next_cur.mem = MEM_IDLE;
        end
      end
      default: next_cur.mem = MEM_IDLE;
    endcase

    if (sys_rst_i) begin
      next_cur         = '0;
      next_cur.s       = '1;
      next_cur.arb     = ARB_CPU;
      next_cur.mem     = MEM_IDLE;
      next_cur.dtack_n = 1'h1;
      next_cur.ras_n   = 1'h1;
      next_cur.cas_n   = 1'h1;
      next_cur.rsel    = REG_SEL_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    cur <= next_cur;
  end

  // ****************************************************************
  // address path
  // ****************************************************************
  // refresh rows replace the dma address; the row half carries the counter
  // column half is loaded while the row strobe stands, so it is out with the column strobe
  assign col_phase = (cur.mem != MEM_IDLE);
  // the refresh choice is made on the starting edge, so the row must follow it then
  assign dma_src   = next_cur.refresh ? {cur.ref_row, cur.ref_row} : dma_addr_i;

  dram_addr_mux u_mux (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .cpu_path_i  (cur.arb == ARB_CPU),
    .col_phase_i (col_phase),
    .cpu_addr_i  (cpu_addr_i),
    .dma_addr_i  (dma_src),
    .dram_addr_o (dram_addr_o)
  );

  assign cpu_dtack_n_o         = cur.dtack_n;
  assign cpu_drivers_en_o      = cur.drv_en;
  assign dma_grant_o           = (cur.arb == ARB_DMA);
  assign dram_ras_n_o          = cur.ras_n;
  assign dram_cas_n_o          = cur.cas_n;
  assign register_select_bus_o = cur.rsel;
  assign dma_done_o            = cur.done;

endmodule : display_bus_arbiter_clock_sync

// [dv/display_bus_arbiter_clock_sync_chk.sv]
`timescale 1ns/1ps
module display_bus_arbiter_clock_sync_chk
  import bus_arb_pkg::*;
(
  input wire logic                   clk_sys_i,
  input wire logic                   sys_rst_i,
  input wire logic                   cpu_display_sel_i,
  input wire logic [CPU_ADDR_W-1:0]  cpu_addr_i,
  input wire logic                   custom_bus_claim_n_i,
  input wire logic [DMA_ADDR_W-1:0]  dma_addr_i,
  input wire logic [REG_SEL_W-1:0]   dma_code_i,
  input wire logic                   refresh_req_i,
  input wire logic                   colour_clock_primary_o,
  input wire logic                   colour_clock_quadrature_o,
  input wire logic                   cpu_clock_double_o,
  input wire logic                   cpu_clock_delayed_o,
  input wire logic                   cpu_dtack_n_o,
  input wire logic                   cpu_drivers_en_o,
  input wire logic                   dma_grant_o,
  input wire logic [DRAM_ADDR_W-1:0] dram_addr_o,
  input wire logic                   dram_ras_n_o,
  input wire logic                   dram_cas_n_o,
  input wire logic [REG_SEL_W-1:0]   register_select_bus_o,
  input wire logic                   dma_done_o
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_dma_ras;
    $fell(dram_ras_n_o) && dma_grant_o && !refresh_req_i;
  endsequence
  property p_colour; $rose(colour_clock_primary_o) |-> colour_clock_primary_o[*4]
    ##1 !colour_clock_primary_o[*4] ##1 colour_clock_primary_o; endproperty
  a_colour: assert property (p_colour) else $error("colour period wrong");
  property p_quad; colour_clock_quadrature_o == $past(colour_clock_primary_o); endproperty
  a_quad: assert property (p_quad) else $error("quadrature lag wrong");
  property p_double; $rose(cpu_clock_double_o) |-> ##4 $rose(cpu_clock_double_o); endproperty
  a_double: assert property (p_double) else $error("doubled clock rate wrong");
  property p_delayed; cpu_clock_delayed_o == $past(cpu_clock_double_o); endproperty
  a_delayed: assert property (p_delayed) else $error("delayed clock lag wrong");
  property p_claim; !custom_bus_claim_n_i[*4] |=> dma_grant_o; endproperty
  a_claim: assert property (p_claim) else $error("claim not granted");
  property p_release; custom_bus_claim_n_i[*8] |-> ##[0:6] !dma_grant_o; endproperty
  a_release: assert property (p_release) else $error("grant not returned");
  property p_drv_off; dma_grant_o |-> !cpu_drivers_en_o; endproperty
  a_drv_off: assert property (p_drv_off) else $error("drivers on under grant");
  property p_no_ack; $fell(cpu_dtack_n_o) && cpu_display_sel_i |-> !$past(dma_grant_o);
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("ack given under grant");
  property p_ack_bus; $fell(cpu_dtack_n_o) && cpu_display_sel_i |-> $past(cpu_drivers_en_o, 4);
  endproperty
  a_ack_bus: assert property (p_ack_bus) else $error("ack before buses");
  property p_ack_phase; $fell(cpu_dtack_n_o) && cpu_display_sel_i
    |-> colour_clock_primary_o || $past(colour_clock_primary_o); endproperty
  a_ack_phase: assert property (p_ack_phase) else $error("ack in wrong phase");
  property p_cpu_addr; $fell(dram_ras_n_o) && cpu_drivers_en_o |-> dram_addr_o == cpu_addr_i[17:9]
    ##1 !dram_cas_n_o && dram_addr_o == cpu_addr_i[8:0]; endproperty
  a_cpu_addr: assert property (p_cpu_addr) else $error("cpu address mux wrong");
  property p_dma_addr; s_dma_ras |-> dram_addr_o == dma_addr_i[17:9]
    ##1 !dram_cas_n_o && dram_addr_o == dma_addr_i[8:0]; endproperty
  a_dma_addr: assert property (p_dma_addr) else $error("dma address mux wrong");
  property p_code; s_dma_ras |-> register_select_bus_o == dma_code_i; endproperty
  a_code: assert property (p_code) else $error("cycle code wrong");
  property p_refresh; $fell(dram_ras_n_o) && refresh_req_i
    |-> register_select_bus_o == REG_SEL_REFRESH ##1 dram_cas_n_o; endproperty
  a_refresh: assert property (p_refresh) else $error("refresh cycle wrong");
  property p_done; s_dma_ras |-> ##[5:9] dma_done_o; endproperty
  a_done: assert property (p_done) else $error("dma cycle not done");
  c_cpu: cover property ($fell(cpu_dtack_n_o) && cpu_display_sel_i);
  c_dma: cover property (s_dma_ras);
  c_refresh: cover property ($fell(dram_ras_n_o) && refresh_req_i);
endmodule : display_bus_arbiter_clock_sync_chk

bind display_bus_arbiter_clock_sync display_bus_arbiter_clock_sync_chk i_chk (
  .clk_sys_i, .sys_rst_i, .cpu_display_sel_i, .cpu_addr_i, .custom_bus_claim_n_i,
  .dma_addr_i, .dma_code_i, .refresh_req_i, .colour_clock_primary_o,
  .colour_clock_quadrature_o, .cpu_clock_double_o, .cpu_clock_delayed_o, .cpu_dtack_n_o,
  .cpu_drivers_en_o, .dma_grant_o, .dram_addr_o, .dram_ras_n_o, .dram_cas_n_o,
  .register_select_bus_o, .dma_done_o);

// [dv/bus_partner.sv]
`timescale 1ns/1ps
module bus_partner
  import bus_arb_pkg::*;
(
  input  wire logic                   clk_sys_i,
  input  wire logic                   cpu_dtack_n_i,
  input  wire logic                   dram_ras_n_i,
  input  wire logic [DRAM_ADDR_W-1:0] dram_addr_i,
  input  wire logic [REG_SEL_W-1:0]   register_select_bus_i,
  output logic                        cpu_as_n_o,
  output logic                        cpu_display_sel_o,
  output logic      [CPU_ADDR_W-1:0]  cpu_addr_o,
  output logic                        custom_bus_claim_n_o,
  output logic                        dma_start_o,
  output logic      [DMA_ADDR_W-1:0]  dma_addr_o,
  output logic      [REG_SEL_W-1:0]   dma_code_o,
  output logic                        refresh_req_o
);
  // ****
  // processor and dma sides
  // ****
  initial begin
    {cpu_as_n_o, cpu_display_sel_o, custom_bus_claim_n_o} = 3'h5;
    {dma_start_o, refresh_req_o, cpu_addr_o, dma_addr_o, dma_code_o} = '0;
  end
  task automatic claim(input logic on);
    @(posedge clk_sys_i);
    custom_bus_claim_n_o <= !on;
  endtask : claim
  // released address lines show the inverse so stale values never match
  task automatic cpu_cycle(input logic disp, input logic [CPU_ADDR_W-1:0] a, output int lat);
    lat = 0;
    @(posedge clk_sys_i);
    cpu_as_n_o <= 1'h0;
    cpu_display_sel_o <= disp;
    cpu_addr_o <= a;
    do begin
      @(posedge clk_sys_i);
      lat++;
    end while (cpu_dtack_n_i !== 1'h0 && lat < 400);
    cpu_as_n_o <= 1'h1;
    cpu_addr_o <= ~a;
    repeat (3) @(posedge clk_sys_i);
  endtask : cpu_cycle
  task automatic dma_cycle(input logic rf, input logic [DMA_ADDR_W-1:0] a,
                           input logic [REG_SEL_W-1:0] code,
                           output logic [REG_SEL_W-1:0] seen_code,
                           output logic [DRAM_ADDR_W-1:0] seen_row);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    dma_start_o <= !rf;
    refresh_req_o <= rf;
    dma_addr_o <= a;
    dma_code_o <= code;
    while (dram_ras_n_i !== 1'h0 && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    // a strobe that never comes hands back a code that cannot match
    seen_code = (n < 40) ? register_select_bus_i : ~code;
    seen_row = dram_addr_i;
    while (dram_ras_n_i !== 1'h1 && n < 80) begin
      @(posedge clk_sys_i);
      n++;
    end
    dma_start_o <= 1'h0;
    refresh_req_o <= 1'h0;
    dma_addr_o <= ~a;
  endtask : dma_cycle
endmodule : bus_partner

// [dv/display_bus_arbiter_clock_sync_tb.sv]
`timescale 1ns/1ps
module display_bus_arbiter_clock_sync_tb;
  import bus_arb_pkg::*;
  logic                   clk_sys_i, sys_rst_i, as_n, sel, claim_n, start, refresh, d, rf;
  logic                   prim, quad, dbl, dly, dtack_n, drv, grant, ras_n, cas_n, done;
  logic                   pp, pd;
  logic [CPU_ADDR_W-1:0]  cpu_addr;
  logic [DMA_ADDR_W-1:0]  dma_addr, a18;
  logic [REG_SEL_W-1:0]   code, rsel, code_s;
  logic [DRAM_ADDR_W-1:0] dram_addr, row_s;
  int                     err_count, checks, lat, np, nd, n;

  display_bus_arbiter_clock_sync i_display_bus_arbiter_clock_sync (
    .clk_sys_i, .sys_rst_i, .cpu_as_n_i(as_n), .cpu_display_sel_i(sel),
    .cpu_addr_i(cpu_addr), .custom_bus_claim_n_i(claim_n), .dma_start_i(start),
    .dma_addr_i(dma_addr), .dma_code_i(code), .refresh_req_i(refresh),
    .colour_clock_primary_o(prim), .colour_clock_quadrature_o(quad),
    .cpu_clock_double_o(dbl), .cpu_clock_delayed_o(dly), .cpu_dtack_n_o(dtack_n),
    .cpu_drivers_en_o(drv), .dma_grant_o(grant), .dram_addr_o(dram_addr),
    .dram_ras_n_o(ras_n), .dram_cas_n_o(cas_n), .register_select_bus_o(rsel),
    .dma_done_o(done));
  bus_partner i_bus_partner (
    .clk_sys_i, .cpu_dtack_n_i(dtack_n), .dram_ras_n_i(ras_n), .dram_addr_i(dram_addr),
    .register_select_bus_i(rsel), .cpu_as_n_o(as_n), .cpu_display_sel_o(sel),
    .cpu_addr_o(cpu_addr), .custom_bus_claim_n_o(claim_n), .dma_start_o(start),
    .dma_addr_o(dma_addr), .dma_code_o(code), .refresh_req_o(refresh));

  // ****
  // checking helpers
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check
  // latency window: wrong start phase may add up to one colour period
  function automatic logic lat_ok(input logic disp, input logic held, input int l);
    if (held) return disp ? (l > 40) : (l <= 6);
    return disp ? (l >= 9 && l <= 28) : (l <= 6);
  endfunction : lat_ok
  task results;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  initial begin
    clk_sys_i = 1'h0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_count++;
    results();
  end

  // ****
  // scenarios
  // ****
  initial begin
    void'($urandom(32'h565bf29c));
    sys_rst_i = 1'h1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_sys_i);
    #1;
    check(32'({dtack_n, drv, grant, ras_n, cas_n, rsel}), 32'h13ff);
    np = 0;
    nd = 0;
    {pp, pd} = {prim, dbl};
    repeat (32) begin
      @(posedge clk_sys_i);
      #1;
      check(32'({quad, dly}), 32'({pp, pd}));
      np += 32'(prim && !pp);
      nd += 32'(dbl && !pd);
      {pp, pd} = {prim, dbl};
    end
    check(32'(np), 32'h4);
    check(32'(nd), 32'h8);
    for (int i = 0; i < 10; i++) begin
      d = (i < 2) ? i[0] : 1'($urandom);
      repeat ($urandom % 8) @(posedge clk_sys_i);
      i_bus_partner.cpu_cycle(d, 23'($urandom), lat);
      check(32'(lat_ok(d, 1'h0, lat)), 32'h1);
    end
    for (int k = 0; k < 2; k++) begin
      i_bus_partner.claim(1'h1);
      n = 0;
      while (grant !== 1'h1 && n < 10) begin
        @(posedge clk_sys_i);
        n++;
      end
      check(32'(grant), 32'h1);
      fork
        i_bus_partner.cpu_cycle(k == 0, 23'($urandom), lat);
        begin
          for (int j = 0; j < 6; j++) begin
            rf = (j == 2);
            a18 = 18'($urandom);
            code = 8'($urandom);
            i_bus_partner.dma_cycle(rf, a18, code, code_s, row_s);
            check(32'(code_s), 32'(rf ? REG_SEL_REFRESH : code));
            if (!rf) check(32'(row_s), 32'(a18[17:9]));
          end
          i_bus_partner.claim(1'h0);
        end
      join
      check(32'(lat_ok(k == 0, 1'h1, lat)), 32'h1);
    end
    repeat (10) @(posedge clk_sys_i);
    results();
  end
endmodule : display_bus_arbiter_clock_sync_tb
